// >>> design/pgtm_pkg.sv
package pgtm_pkg;

    localparam logic [7:0] OUT2_REG_MASK_OFS   = 8'ha8;
    localparam logic [7:0] OUT2_PIN_MASK_OFS   = 8'ha9;
    localparam logic [7:0] OUT3_REG_MASK_OFS   = 8'haa;
    localparam logic [7:0] OUT3_PIN_MASK_OFS   = 8'hab;

    localparam logic [7:0] OUT2_REG_MASK_RST   = 8'hc0;
    localparam logic [7:0] OUT2_PIN_MASK_RST   = 8'h2f;
    localparam logic [7:0] OUT3_REG_MASK_RST   = 8'h00;
    localparam logic [7:0] OUT3_PIN_MASK_RST   = 8'h00;

    // Bit positions of the second mask register.
    localparam int CTL_IN_5_BIT       = 7;
    localparam int CTL_IN_4_BIT       = 6;
    localparam int CTL_IN_2_BIT       = 5;
    localparam int CTL_IN_1_BIT       = 4;
    localparam int TERMINATION_BIT    = 3;
    localparam int SWITCH_B2_BIT      = 2;
    localparam int SWITCH_B1_BIT      = 1;
    localparam int LDO_A3_B_BIT       = 0;

    // Bit positions of the first mask register.
    localparam int LDO_A2_A_BIT       = 7;
    localparam int SWITCH_A1_BIT      = 6;
    localparam int STEP_DOWN_6_BIT    = 5;
    localparam int STEP_DOWN_1_BIT    = 0;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgtm_req_type;

    typedef struct packed {
        logic [7:0] regulatorGood;
        logic [7:0] pinSwitchGood;
    } pgtm_src_type;

endpackage

// >>> design/pgtm_power_good_tree_masks.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] Output 2 first mask: bits 7..0 ldo_a2_a, switch_a1, step_down_6..1; 1 excludes.
// [RULE2] Output 2 second mask bits 7..4 gate ctl_in_5, ctl_in_4, ctl_in_2, ctl_in_1.
// [RULE3] Output 2 second mask bits 3..0 gate termination, switch_b2, switch_b1, ldo_a3_b.
// [RULE4] Output 3 has its own identical pair of masks, independent of output 2.
// [RULE5] Output 2 first mask at A8h, resets to C0h.
// [RULE6] Output 2 second mask at A9h, resets to 2Fh.
// [RULE7] Output 3 masks at AAh and ABh, both reset to zero.
// [RULE8] A regulator flag is 1 when its output is within regulation.
// [RULE9] A pin shows good only when every included source is good.
module pgtm_power_good_tree_masks (
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire pgtm_pkg::pgtm_req_type regReq,
    output logic [7:0]                  regRdata,
    output logic                        regHit,
    input  wire pgtm_pkg::pgtm_src_type srcGood,
    output logic                        outputPin2Good,
    output logic                        outputPin3Good
);

    // Sources come from analog comparators and pins, so they are synchronised first.
    pgtm_pkg::pgtm_src_type srcMeta_reg;
    pgtm_pkg::pgtm_src_type srcSync_reg;

    logic [7:0] out2RegMask_reg;
    logic [7:0] out2PinMask_reg;
    logic [7:0] out3RegMask_reg;
    logic [7:0] out3PinMask_reg;
    logic [7:0] regRdata_next;
    logic       regHit_next;
    logic       pin2Good_next;
    logic       pin3Good_next;

    // Positions of the regulator sources in the first mask register.
    localparam int LdoA2A    = pgtm_pkg::LDO_A2_A_BIT;
    localparam int SwitchA1  = pgtm_pkg::SWITCH_A1_BIT;
    localparam int StepDown6 = pgtm_pkg::STEP_DOWN_6_BIT;
    localparam int StepDown5 = pgtm_pkg::STEP_DOWN_1_BIT + 4;
    localparam int StepDown4 = pgtm_pkg::STEP_DOWN_1_BIT + 3;
    localparam int StepDown3 = pgtm_pkg::STEP_DOWN_1_BIT + 2;
    localparam int StepDown2 = pgtm_pkg::STEP_DOWN_1_BIT + 1;
    localparam int StepDown1 = pgtm_pkg::STEP_DOWN_1_BIT;

    // Positions of the pin and switch sources in the second mask register.
    localparam int CtlIn5    = pgtm_pkg::CTL_IN_5_BIT;
    localparam int CtlIn4    = pgtm_pkg::CTL_IN_4_BIT;
    localparam int CtlIn2    = pgtm_pkg::CTL_IN_2_BIT;
    localparam int CtlIn1    = pgtm_pkg::CTL_IN_1_BIT;
    localparam int TermReg   = pgtm_pkg::TERMINATION_BIT;
    localparam int SwitchB2  = pgtm_pkg::SWITCH_B2_BIT;
    localparam int SwitchB1  = pgtm_pkg::SWITCH_B1_BIT;
    localparam int LdoA3B    = pgtm_pkg::LDO_A3_B_BIT;

    // An excluded source reads as good, so it can never pull its tree low.
    function automatic logic source_ok(input logic [7:0] good,
                                       input logic [7:0] exclude,
                                       input int         pos);
        source_ok = good[pos] | exclude[pos]; // [RULE9]
    endfunction

    wire [7:0] regGood = srcSync_reg.regulatorGood; // [RULE8]
    wire [7:0] pinGood = srcSync_reg.pinSwitchGood;
    wire [7:0] pin2RegOk;
    wire [7:0] pin2PinOk;
    wire [7:0] pin3RegOk;
    wire [7:0] pin3PinOk;

    // Each source is wired by name so the map does not hang on vector order.
    assign pin2RegOk[LdoA2A]    = source_ok(regGood, out2RegMask_reg, LdoA2A); // [RULE1]
    assign pin2RegOk[SwitchA1]  = source_ok(regGood, out2RegMask_reg, SwitchA1); // [RULE1]
    assign pin2RegOk[StepDown6] = source_ok(regGood, out2RegMask_reg, StepDown6); // [RULE1]
    assign pin2RegOk[StepDown5] = source_ok(regGood, out2RegMask_reg, StepDown5); // [RULE1]
    assign pin2RegOk[StepDown4] = source_ok(regGood, out2RegMask_reg, StepDown4); // [RULE1]
    assign pin2RegOk[StepDown3] = source_ok(regGood, out2RegMask_reg, StepDown3); // [RULE1]
    assign pin2RegOk[StepDown2] = source_ok(regGood, out2RegMask_reg, StepDown2); // [RULE1]
    assign pin2RegOk[StepDown1] = source_ok(regGood, out2RegMask_reg, StepDown1); // [RULE1]
    assign pin2PinOk[CtlIn5]    = source_ok(pinGood, out2PinMask_reg, CtlIn5); // [RULE2]
    assign pin2PinOk[CtlIn4]    = source_ok(pinGood, out2PinMask_reg, CtlIn4); // [RULE2]
    assign pin2PinOk[CtlIn2]    = source_ok(pinGood, out2PinMask_reg, CtlIn2); // [RULE2]
    assign pin2PinOk[CtlIn1]    = source_ok(pinGood, out2PinMask_reg, CtlIn1); // [RULE2]
    assign pin2PinOk[TermReg]   = source_ok(pinGood, out2PinMask_reg, TermReg); // [RULE3]
    assign pin2PinOk[SwitchB2]  = source_ok(pinGood, out2PinMask_reg, SwitchB2); // [RULE3]
    assign pin2PinOk[SwitchB1]  = source_ok(pinGood, out2PinMask_reg, SwitchB1); // [RULE3]
    assign pin2PinOk[LdoA3B]    = source_ok(pinGood, out2PinMask_reg, LdoA3B); // [RULE3]

    // Output 3 uses the same map with its own masks, so the trees never interact.
    assign pin3RegOk[LdoA2A]    = source_ok(regGood, out3RegMask_reg, LdoA2A); // [RULE4]
    assign pin3RegOk[SwitchA1]  = source_ok(regGood, out3RegMask_reg, SwitchA1); // [RULE4]
    assign pin3RegOk[StepDown6] = source_ok(regGood, out3RegMask_reg, StepDown6); // [RULE4]
    assign pin3RegOk[StepDown5] = source_ok(regGood, out3RegMask_reg, StepDown5); // [RULE4]
    assign pin3RegOk[StepDown4] = source_ok(regGood, out3RegMask_reg, StepDown4); // [RULE4]
    assign pin3RegOk[StepDown3] = source_ok(regGood, out3RegMask_reg, StepDown3); // [RULE4]
    assign pin3RegOk[StepDown2] = source_ok(regGood, out3RegMask_reg, StepDown2); // [RULE4]
    assign pin3RegOk[StepDown1] = source_ok(regGood, out3RegMask_reg, StepDown1); // [RULE4]
    assign pin3PinOk[CtlIn5]    = source_ok(pinGood, out3PinMask_reg, CtlIn5); // [RULE4]
    assign pin3PinOk[CtlIn4]    = source_ok(pinGood, out3PinMask_reg, CtlIn4); // [RULE4]
    assign pin3PinOk[CtlIn2]    = source_ok(pinGood, out3PinMask_reg, CtlIn2); // [RULE4]
    assign pin3PinOk[CtlIn1]    = source_ok(pinGood, out3PinMask_reg, CtlIn1); // [RULE4]
    assign pin3PinOk[TermReg]   = source_ok(pinGood, out3PinMask_reg, TermReg); // [RULE4]
    assign pin3PinOk[SwitchB2]  = source_ok(pinGood, out3PinMask_reg, SwitchB2); // [RULE4]
    assign pin3PinOk[SwitchB1]  = source_ok(pinGood, out3PinMask_reg, SwitchB1); // [RULE4]
    assign pin3PinOk[LdoA3B]    = source_ok(pinGood, out3PinMask_reg, LdoA3B); // [RULE4]

    wire selOut2Reg = regReq.addr == pgtm_pkg::OUT2_REG_MASK_OFS;
    wire selOut2Pin = regReq.addr == pgtm_pkg::OUT2_PIN_MASK_OFS;
    wire selOut3Reg = regReq.addr == pgtm_pkg::OUT3_REG_MASK_OFS;
    wire selOut3Pin = regReq.addr == pgtm_pkg::OUT3_PIN_MASK_OFS;

    // Unmapped addresses belong to other register banks, so this bank reads zero there.
    assign regHit_next   = selOut2Reg | selOut2Pin | selOut3Reg | selOut3Pin;
    assign regRdata_next = !regReq.read ? 8'h00 :
                           selOut2Reg   ? out2RegMask_reg :
                           selOut2Pin   ? out2PinMask_reg :
                           selOut3Reg   ? out3RegMask_reg :
                           selOut3Pin   ? out3PinMask_reg : 8'h00;

    assign pin2Good_next = &{pin2RegOk, pin2PinOk}; // [RULE9]
    assign pin3Good_next = &{pin3RegOk, pin3PinOk}; // [RULE9]

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            srcMeta_reg <= '0;
            srcSync_reg <= '0;
        end else begin
            srcMeta_reg <= srcGood;
            srcSync_reg <= srcMeta_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out2RegMask_reg <= pgtm_pkg::OUT2_REG_MASK_RST; // [RULE5]
            out2PinMask_reg <= pgtm_pkg::OUT2_PIN_MASK_RST; // [RULE6]
            out3RegMask_reg <= pgtm_pkg::OUT3_REG_MASK_RST; // [RULE7]
            out3PinMask_reg <= pgtm_pkg::OUT3_PIN_MASK_RST; // [RULE7]
        end else if (regReq.write) begin
            if (selOut2Reg) out2RegMask_reg <= regReq.wdata; // [RULE5]
            if (selOut2Pin) out2PinMask_reg <= regReq.wdata; // [RULE6]
            if (selOut3Reg) out3RegMask_reg <= regReq.wdata; // [RULE7]
            if (selOut3Pin) out3PinMask_reg <= regReq.wdata; // [RULE7]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata       <= 8'h00;
            regHit         <= 1'b0;
            outputPin2Good <= 1'b0;
            outputPin3Good <= 1'b0;
        end else begin
            regRdata       <= regRdata_next;
            regHit         <= regHit_next;
            outputPin2Good <= pin2Good_next;
            outputPin3Good <= pin3Good_next;
        end
    end

endmodule // pgtm_power_good_tree_masks

// >>> verif/pgtm_checker.sv
`timescale 1ns/1ps
module pgtm_checker (input wire logic core_clk, rst_b, regHit, outputPin2Good, outputPin3Good,
    input wire pgtm_pkg::pgtm_req_type regReq, input wire pgtm_pkg::pgtm_src_type srcGood,
    input wire logic [7:0] regRdata);
    wire inMap = regReq.addr inside {[8'ha8:8'hab]};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_hit; inMap |=> regHit; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_miss; !inMap |=> !regHit; endproperty
    a_miss: assert property (p_miss) else $error("stray hit");
    property p_idle; !regReq.read |=> regRdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_unm; regReq.read && !inMap |=> regRdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_back; regReq.write && inMap ##1 regReq.read && $stable(regReq.addr)
        |=> regRdata == $past(regReq.wdata, 2); endproperty
    a_back: assert property (p_back) else $error("readback");
    property p_rst; $rose(rst_b) |-> !regHit && regRdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_all; (srcGood == '1) [*5] |-> outputPin2Good && outputPin3Good; endproperty
    a_all: assert property (p_all) else $error("all good low");
    property p_stab; ($stable(srcGood) && !regReq.write) [*4]
        |=> $stable(outputPin2Good) && $stable(outputPin3Good); endproperty
    a_stab: assert property (p_stab) else $error("pin moved");
    c_back: cover property (regReq.write ##1 regReq.read);
    c_fall: cover property ($fell(outputPin2Good));
    c_rise: cover property ($rose(outputPin3Good));
endmodule // pgtm_checker
bind pgtm_power_good_tree_masks pgtm_checker pgtm_checker_i (.*);

// >>> verif/pgtm_host.sv
`timescale 1ns/1ps
module pgtm_host (
    input wire logic             core_clk,
    output pgtm_pkg::pgtm_req_type req
);
    initial req = '0;
    // Requests change only at the falling edge, well clear of the sampling edge.
    task automatic acc(input logic w, r, input logic [7:0] a, d);
        @(negedge core_clk);
        req <= {w, r, a, d};
    endtask
endmodule // pgtm_host

// >>> verif/tb_power_good_tree_masks.sv
`timescale 1ns/1ps
module tb_power_good_tree_masks;
    logic core_clk = 1'b0, rst_b = 1'b0, regHit, outputPin2Good, outputPin3Good;
    logic [7:0] regRdata;
    pgtm_pkg::pgtm_req_type regReq;
    pgtm_pkg::pgtm_src_type srcGood = '0;
    int bad_count = 0, checked = 0;
    logic [47:0] rows [5] = '{48'hffff_0000_0000, 48'h0000_ffff_fffe, 48'h7fff_80ff_7fff,
        48'hfffe_ff01_fffe, 48'h0000_0000_ffff};
    // Expected {output 2, output 3} for each row, worked out by hand.
    logic [1:0] want [5] = '{2'b10, 2'b01, 2'b01, 2'b01, 2'b11};
    initial forever #5 core_clk = ~core_clk;
    pgtm_host pgtm_host_i (.core_clk(core_clk), .req(regReq));
    pgtm_power_good_tree_masks pgtm_power_good_tree_masks_i (.*);
    task automatic chk(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, e);
        pgtm_host_i.acc(1'b0, 1'b1, a, 8'h00);
        pgtm_host_i.acc(1'b0, 1'b0, 8'h00, 8'h00);
        chk(regRdata, e);
    endtask
    task automatic stop_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            for (int k = 0; k < 4; k++)
                pgtm_host_i.acc(1'b1, 1'b0, 8'ha8 + 8'(k), rows[i][47-8*k-:8]);
            srcGood = rows[i][15:0];
            repeat (5) pgtm_host_i.acc(1'b0, 1'b0, 8'h00, 8'h00);
            chk({7'h0, outputPin2Good}, {7'h0, want[i][1]});
            chk({7'h0, outputPin3Good}, {7'h0, want[i][0]});
            $display("row %0d done", i);
        end
        pgtm_host_i.acc(1'b1, 1'b0, 8'ha9, 8'h5a);
        pgtm_host_i.acc(1'b1, 1'b1, 8'ha9, 8'ha5);
        rd(8'ha9, 8'ha5);
        chk({7'h0, regHit}, 8'h01);
        rd(8'hac, 8'h00);
        chk({7'h0, regHit}, 8'h00);
        $display("access done");
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        rd(8'ha8, 8'hc0);
        rd(8'ha9, 8'h2f);
        rd(8'haa, 8'h00);
        rd(8'hab, 8'h00);
        $display("reset done");
        stop_test;
    end
endmodule // tb_power_good_tree_masks
